// file: hdl/pio_pkg.sv
// Constants for the upper parallel port with change detection.
// What this block does
// (RULE_01) Status bit 31 reads one while the host interrupt request is asserted.
// (RULE_02) Status bits 23..16 show channel seven..zero interrupt requests after their masks.
// (RULE_03) Status bit 0 mirrors the software test interrupt bit, unmasked.
// (RULE_04) Status bit 4 is the OR of enabled captured rising events.
// (RULE_05) Status bit 5 is the OR of enabled captured falling events.
// (RULE_06) Rise and fall summaries ignore master enable; requests need master enable.
// (RULE_07) Status bit 15 is FIFO level at or above threshold, gated by level enable.
// (RULE_08) Direction register resets to zero; a one makes that line an output.
// (RULE_09) A line drives only with direction one and parallel enable set.
// (RULE_10) Data port reads present pin levels with no processing.
// (RULE_11) Data writes load the output latch; a separate port reads it back.
// (RULE_12) Enabled low-to-high change sets the captured rising bit, outputs included.
// (RULE_13) Enabled high-to-low change sets the captured falling bit, outputs included.
// (RULE_14) Captured event requests interrupt only with its line mask and master enable.
// (RULE_15) Control bit 0 holds the change FIFO in reset; power-on reset clears it.
// (RULE_16) Control bit 7 starts detection, synchronised to the detection clock first.
// (RULE_17) Control bit 8 puts the detection clock on line 32 output data.
// (RULE_18) Control bit 11 gates the level interrupt; unmasked condition stays visible.
// (RULE_19) Control bit 14 selects oscillator or synthesizer output A, divided by ten.
// (RULE_20) Software programs clocks, direction and edge selects before enabling detection.
// (RULE_21) Software writes output data and parallel enable before setting direction.
// (RULE_22) Captured bits hold until written with one; zero leaves them.
// (RULE_23) Master enable gates test, rise and fall sources onto the interrupt line.
// (RULE_24) Each edge detector gives a pulse lasting exactly one detection clock cycle.
// (RULE_25) Each input passes a two-stage synchroniser in the detection domain.
// (RULE_26) Detection clock divides the reference by ten; select change resets the divider.
package pio_pkg;
	localparam logic [7:0] OFS_BASE_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS      = 8'h08;
	localparam logic [7:0] OFS_DIR         = 8'h0C;
	localparam logic [7:0] OFS_DATA        = 8'h10;
	localparam logic [7:0] OFS_LATCH       = 8'h14;
	localparam logic [7:0] OFS_RISE_SEL    = 8'h18;
	localparam logic [7:0] OFS_FALL_SEL    = 8'h1C;
	localparam logic [7:0] OFS_RISE_MASK   = 8'h20;
	localparam logic [7:0] OFS_FALL_MASK   = 8'h24;
	localparam logic [7:0] OFS_CTRL        = 8'h28;
	localparam logic [7:0] OFS_CHG_STATUS  = 8'h2C;
	localparam logic [7:0] OFS_THRESHOLD   = 8'h30;
	localparam logic [7:0] OFS_RISE_CAP    = 8'h3C;
	localparam logic [7:0] OFS_FALL_CAP    = 8'h40;

	localparam int BIT_MASTER_IRQ  = 0;
	localparam int BIT_FORCE_IRQ   = 1;
	localparam int BIT_FIFO_RESET  = 0;
	localparam int BIT_RUN         = 7;
	localparam int BIT_TEST_CLK    = 8;
	localparam int BIT_LEVEL_IRQ   = 11;
	localparam int BIT_CLK_SEL     = 14;
	localparam int BIT_ST_LOCAL    = 0;
	localparam int BIT_ST_RISE     = 4;
	localparam int BIT_ST_FALL     = 5;
	localparam int BIT_ST_LEVEL    = 15;
	localparam int BIT_ST_CHAN_LO  = 16;
	localparam int BIT_ST_IRQ      = 31;
	localparam int BIT_CS_COUNT_LO = 16;
	localparam int BIT_CS_RAW      = 30;
	localparam int BIT_CS_MASKED   = 31;

	localparam logic [31:0] DIR_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_4981;
	localparam logic [31:0] BASE_WMASK = 32'h0000_0003;
	localparam int          REF_DIVIDE = 10;
	localparam int          LEVEL_W    = 14;
endpackage

// file: hdl/edge_capture.sv
// Per-line synchroniser, edge detection and sticky capture for the change detector.
`timescale 1ns/1ps
`default_nettype none
module edge_capture #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire  logic             core_clk,
	input  wire  logic             rstn,
	// Detection timing
	input  wire  logic             tick,
	input  wire  logic             run,
	// Lines and selections
	input  wire  logic [WIDTH-1:0] pins,
	input  wire  logic [WIDTH-1:0] rise_sel,
	input  wire  logic [WIDTH-1:0] fall_sel,
	// Write-one clears
	input  wire  logic [WIDTH-1:0] rise_clr,
	input  wire  logic [WIDTH-1:0] fall_clr,
	// Results
	output logic       [WIDTH-1:0] rise_pulse,
	output logic       [WIDTH-1:0] fall_pulse,
	output logic       [WIDTH-1:0] rise_captured,
	output logic       [WIDTH-1:0] fall_captured
);
	logic [WIDTH-1:0] sync_first;
	logic [WIDTH-1:0] sync_second;
	logic [WIDTH-1:0] prev_level;
	wire  [WIDTH-1:0] rise_edge;
	wire  [WIDTH-1:0] fall_edge;
	wire  [WIDTH-1:0] rise_set;
	wire  [WIDTH-1:0] fall_set;

	assign rise_edge = sync_second & ~prev_level & rise_sel & {WIDTH{run}};  // see RULE_12
	assign fall_edge = ~sync_second & prev_level & fall_sel & {WIDTH{run}};  // see RULE_13
	assign rise_set  = rise_edge & {WIDTH{tick}};
	assign fall_set  = fall_edge & {WIDTH{tick}};

	// ==========================================================
	// Synchroniser, advanced once per detection clock.
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			sync_first  <= '0;
			sync_second <= '0;
			prev_level  <= '0;
		end
		else if (tick)
		begin
			sync_first  <= pins;         // see RULE_25
			sync_second <= sync_first;   // see RULE_25
			prev_level  <= sync_second;
		end
	end

	// ==========================================================
	// Pulses last until the next detection tick, one detection cycle.
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rise_pulse <= '0;
			fall_pulse <= '0;
		end
		else if (tick)
		begin
			rise_pulse <= rise_edge;  // see RULE_24
			fall_pulse <= fall_edge;  // see RULE_24
		end
	end

	// ==========================================================
	// Sticky capture; a new event in the clearing cycle survives.
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			rise_captured <= '0;
			fall_captured <= '0;
		end
		else
		begin
			rise_captured <= (rise_captured & ~rise_clr) | rise_set;  // see RULE_22
			fall_captured <= (fall_captured & ~fall_clr) | fall_set;  // see RULE_22
		end
	end
endmodule
`default_nettype wire

// file: hdl/parallel_io_change_detect.sv
// Upper 32 parallel lines with direction, readback, change detection and board status.
`timescale 1ns/1ps
`default_nettype none
module parallel_io_change_detect #(
	parameter int LINES = 32
) (
	// Clock and reset
	input  wire  logic             core_clk,
	input  wire  logic             rstn,
	// Register port
	input  wire  logic [7:0]       reg_addr,
	input  wire  logic             reg_wr_en,
	input  wire  logic             reg_rd_en,
	input  wire  logic [31:0]      reg_wdata,
	output logic       [31:0]      reg_rdata,
	output logic                   reg_rvalid,
	// Parallel lines
	input  wire  logic [LINES-1:0] io_in,
	output logic       [LINES-1:0] io_out,
	output logic       [LINES-1:0] io_oe,
	input  wire  logic             parallel_enable,
	// Detection references
	input  wire  logic             osc_ref,
	input  wire  logic             synth_output_a,
	// Change FIFO and channel neighbours
	input  wire  logic [pio_pkg::LEVEL_W-1:0] fifo_level,
	output logic                   fifo_clear,
	input  wire  logic [7:0]       channel_irq_lines,
	// Host interrupt
	output logic                   irq_request
);
	// ==========================================================
	// Registers
	logic [31:0]      base_control;
	logic [LINES-1:0] pin_direction_bits;
	logic [LINES-1:0] output_latch;
	logic [LINES-1:0] rise_detect_select;
	logic [LINES-1:0] fall_detect_select;
	logic [LINES-1:0] rise_irq_mask;
	logic [LINES-1:0] fall_irq_mask;
	logic [31:0]      change_engine_control;
	logic [pio_pkg::LEVEL_W-1:0] fifo_threshold;

	// ==========================================================
	// Detection clock state
	logic       ref_prev;
	logic       sel_prev;
	logic [3:0] div_count;
	logic       tick;
	logic       det_clk;
	logic       run_first;
	logic       change_detect_run;

	wire [LINES-1:0] rise_pulse;
	wire [LINES-1:0] fall_pulse;
	wire [LINES-1:0] rise_captured;
	wire [LINES-1:0] fall_captured;

	// ==========================================================
	// Decode
	wire wr_base      = reg_wr_en && reg_addr == pio_pkg::OFS_BASE_CTRL;
	wire wr_dir       = reg_wr_en && reg_addr == pio_pkg::OFS_DIR;
	wire wr_data      = reg_wr_en && reg_addr == pio_pkg::OFS_DATA;
	wire wr_rise_sel  = reg_wr_en && reg_addr == pio_pkg::OFS_RISE_SEL;
	wire wr_fall_sel  = reg_wr_en && reg_addr == pio_pkg::OFS_FALL_SEL;
	wire wr_rise_mask = reg_wr_en && reg_addr == pio_pkg::OFS_RISE_MASK;
	wire wr_fall_mask = reg_wr_en && reg_addr == pio_pkg::OFS_FALL_MASK;
	wire wr_ctrl      = reg_wr_en && reg_addr == pio_pkg::OFS_CTRL;
	wire wr_thresh    = reg_wr_en && reg_addr == pio_pkg::OFS_THRESHOLD;
	wire wr_rise_cap  = reg_wr_en && reg_addr == pio_pkg::OFS_RISE_CAP;
	wire wr_fall_cap  = reg_wr_en && reg_addr == pio_pkg::OFS_FALL_CAP;

	wire [LINES-1:0] rise_clr = wr_rise_cap ? reg_wdata[LINES-1:0] : '0;  // see RULE_22
	wire [LINES-1:0] fall_clr = wr_fall_cap ? reg_wdata[LINES-1:0] : '0;  // see RULE_22

	// ==========================================================
	// Interrupt sources
	wire master_irq = base_control[pio_pkg::BIT_MASTER_IRQ];
	wire force_irq  = base_control[pio_pkg::BIT_FORCE_IRQ];
	// Summaries are taken before the master enable so polling still works.
	wire rise_event_summary = |(rise_captured & rise_detect_select);  // see RULE_04, RULE_06
	wire fall_event_summary = |(fall_captured & fall_detect_select);  // see RULE_05, RULE_06
	wire rise_masked        = |(rise_captured & rise_irq_mask);       // see RULE_14
	wire fall_masked        = |(fall_captured & fall_irq_mask);       // see RULE_14
	wire level_raw          = fifo_level >= fifo_threshold;           // see RULE_18
	wire fifo_threshold_irq = level_raw && change_engine_control[pio_pkg::BIT_LEVEL_IRQ];  // see RULE_07
	wire gated_sources      = master_irq && (force_irq || rise_masked || fall_masked);  // see RULE_23, RULE_06
	// Channel and level sources have their own enables and bypass the master enable.
	wire next_irq           = gated_sources || fifo_threshold_irq || |channel_irq_lines;

	// ==========================================================
	// Status words
	wire [31:0] board_irq_summary = {
		irq_request,         // see RULE_01
		7'h00,
		channel_irq_lines,   // see RULE_02
		fifo_threshold_irq,  // see RULE_07
		9'h000,
		fall_event_summary,  // see RULE_05
		rise_event_summary,  // see RULE_04
		3'h0,
		force_irq            // see RULE_03
	};
	// The count fills bits 29..16, so the two level flags sit directly above it with no padding.
	wire [31:0] change_status = {
		fifo_threshold_irq,
		level_raw,           // see RULE_18
		fifo_level,
		16'h0000
	};

	// ==========================================================
	// Reference selection and divide by ten
	wire clk_sel    = change_engine_control[pio_pkg::BIT_CLK_SEL];
	wire ref_level  = clk_sel ? synth_output_a : osc_ref;  // see RULE_19
	wire ref_rise   = ref_level && !ref_prev;
	wire sel_change = clk_sel != sel_prev;
	wire div_last   = div_count == 4'(pio_pkg::REF_DIVIDE - 1);
	wire [3:0] next_div_count = sel_change ? 4'h0 :
		(ref_rise ? (div_last ? 4'h0 : div_count + 4'h1) : div_count);  // see RULE_26
	wire next_tick    = ref_rise && div_last && !sel_change;
	wire next_det_clk = next_div_count < 4'(pio_pkg::REF_DIVIDE / 2);

	// ==========================================================
	// Line drive
	wire test_clk = change_engine_control[pio_pkg::BIT_TEST_CLK];
	wire [LINES-1:0] next_io_out = {output_latch[LINES-1:1], test_clk ? det_clk : output_latch[0]};  // see RULE_17
	wire [LINES-1:0] next_io_oe  = pin_direction_bits & {LINES{parallel_enable}};  // see RULE_09

	// ==========================================================
	// Read selection
	function automatic logic [31:0] widen(input logic [LINES-1:0] v);
		widen = 32'(v);
	endfunction

	logic [31:0] next_rdata;
	always_comb
	begin
		case (reg_addr)
			pio_pkg::OFS_BASE_CTRL:  next_rdata = base_control;
			pio_pkg::OFS_STATUS:     next_rdata = board_irq_summary;
			pio_pkg::OFS_DIR:        next_rdata = widen(pin_direction_bits);
			pio_pkg::OFS_DATA:       next_rdata = widen(io_in);  // see RULE_10
			pio_pkg::OFS_LATCH:      next_rdata = widen(output_latch);  // see RULE_11
			pio_pkg::OFS_RISE_SEL:   next_rdata = widen(rise_detect_select);
			pio_pkg::OFS_FALL_SEL:   next_rdata = widen(fall_detect_select);
			pio_pkg::OFS_RISE_MASK:  next_rdata = widen(rise_irq_mask);
			pio_pkg::OFS_FALL_MASK:  next_rdata = widen(fall_irq_mask);
			pio_pkg::OFS_CTRL:       next_rdata = change_engine_control;
			pio_pkg::OFS_CHG_STATUS: next_rdata = change_status;  // see RULE_18
			pio_pkg::OFS_THRESHOLD:  next_rdata = 32'(fifo_threshold);
			pio_pkg::OFS_RISE_CAP:   next_rdata = widen(rise_captured);
			pio_pkg::OFS_FALL_CAP:   next_rdata = widen(fall_captured);
			default:                 next_rdata = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Software registers: control words
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			base_control          <= 32'h0000_0000;
			change_engine_control <= 32'h0000_0000;
			fifo_threshold        <= '0;
		end
		else
		begin
			if (wr_base)
				base_control <= reg_wdata & pio_pkg::BASE_WMASK;
			if (wr_ctrl)
				change_engine_control <= reg_wdata & pio_pkg::CTRL_WMASK;
			if (wr_thresh)
				fifo_threshold <= reg_wdata[pio_pkg::LEVEL_W-1:0];
		end
	end

	// ==========================================================
	// Software registers: per-line words
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			pin_direction_bits    <= pio_pkg::DIR_RESET;  // see RULE_08
			output_latch          <= '0;
			rise_detect_select    <= '0;
			fall_detect_select    <= '0;
			rise_irq_mask         <= '0;
			fall_irq_mask         <= '0;
		end
		else
		begin
			if (wr_dir)
				pin_direction_bits <= reg_wdata[LINES-1:0];  // see RULE_08
			if (wr_data)
				output_latch <= reg_wdata[LINES-1:0];  // see RULE_11
			if (wr_rise_sel)
				rise_detect_select <= reg_wdata[LINES-1:0];
			if (wr_fall_sel)
				fall_detect_select <= reg_wdata[LINES-1:0];
			if (wr_rise_mask)
				rise_irq_mask <= reg_wdata[LINES-1:0];
			if (wr_fall_mask)
				fall_irq_mask <= reg_wdata[LINES-1:0];
		end
	end

	// ==========================================================
	// Read answer, one cycle after the request
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			reg_rdata  <= 32'h0000_0000;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd_en;
			if (reg_rd_en)
				reg_rdata <= next_rdata;
		end
	end

	// ==========================================================
	// Detection clock divider
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			ref_prev  <= 1'b0;
			sel_prev  <= 1'b0;
			div_count <= 4'h0;
			tick      <= 1'b0;
			det_clk   <= 1'b1;
		end
		else
		begin
			ref_prev  <= ref_level;
			sel_prev  <= clk_sel;
			div_count <= next_div_count;  // see RULE_26
			tick      <= next_tick;
			det_clk   <= next_det_clk;
		end
	end

	// ==========================================================
	// Enable carried into the detection timing by two ticks.
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			run_first         <= 1'b0;
			change_detect_run <= 1'b0;
		end
		else if (tick)
		begin
			run_first         <= change_engine_control[pio_pkg::BIT_RUN];  // see RULE_16
			change_detect_run <= run_first;                                // see RULE_16
		end
	end

	// ==========================================================
	// Outputs
	// The request is registered, and status bit 31 reads that register, so a read never disagrees with the pin.
	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			io_out      <= '0;
			io_oe       <= '0;
			fifo_clear  <= 1'b1;
			irq_request <= 1'b0;
		end
		else
		begin
			io_out      <= next_io_out;
			io_oe       <= next_io_oe;  // see RULE_09
			fifo_clear  <= change_engine_control[pio_pkg::BIT_FIFO_RESET];  // see RULE_15
			irq_request <= next_irq;  // see RULE_01
		end
	end

	// ==========================================================
	// Per-line edge engine; it sees pin levels, so output lines are watched too.
	edge_capture #(
		.WIDTH (LINES)
	) u_edges (
		.core_clk      (core_clk),
		.rstn          (rstn),
		.tick          (tick),
		.run           (change_detect_run),
		.pins          (io_in),
		.rise_sel      (rise_detect_select),
		.fall_sel      (fall_detect_select),
		.rise_clr      (rise_clr),
		.fall_clr      (fall_clr),
		.rise_pulse    (rise_pulse),
		.fall_pulse    (fall_pulse),
		.rise_captured (rise_captured),
		.fall_captured (fall_captured)
	);
endmodule
`default_nettype wire

// file: tb/pio_chk.sv
// Port checker for the upper parallel line block.
`timescale 1ns/1ps
`default_nettype none
module pio_chk #(
	parameter int LINES = 32
) (
	// Clock, reset and register port
	input wire logic             core_clk,
	input wire logic             rstn,
	input wire logic [7:0]       reg_addr,
	input wire logic             reg_wr_en,
	input wire logic             reg_rd_en,
	input wire logic [31:0]      reg_wdata,
	input wire logic [31:0]      reg_rdata,
	input wire logic             reg_rvalid,
	// Lines and board signals
	input wire logic [LINES-1:0] io_out,
	input wire logic [LINES-1:0] io_oe,
	input wire logic             parallel_enable,
	input wire logic             fifo_clear,
	input wire logic [7:0]       channel_irq_lines,
	input wire logic             irq_request
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire st_rd  = reg_rd_en && reg_addr == pio_pkg::OFS_STATUS;
	wire dat_wr = reg_wr_en && reg_addr == pio_pkg::OFS_DATA;
	wire clr_wr = reg_wr_en && reg_addr == pio_pkg::OFS_CTRL && reg_wdata[0];
	property p_irq_st;
		st_rd |=> reg_rvalid && reg_rdata[31] == $past(irq_request);
	endproperty
	a_irq_st: assert property (p_irq_st) else $error("status irq bit wrong");
	property p_chan_st;
		st_rd |=> reg_rdata[23:16] == $past(channel_irq_lines);
	endproperty
	a_chan_st: assert property (p_chan_st) else $error("status channel bits wrong");
	property p_rvalid;
		!reg_rd_en |=> !reg_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read answer without request");
	property p_oe_rst;
		$rose(rstn) |-> io_oe == '0;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("lines driven after reset");
	property p_oe_pe;
		!parallel_enable |=> io_oe == '0;
	endproperty
	a_oe_pe: assert property (p_oe_pe) else $error("line driven without enable");
	property p_out_wr;
		dat_wr ##1 !dat_wr |=> io_out[LINES-1:1] == $past(reg_wdata[LINES-1:1], 2);
	endproperty
	a_out_wr: assert property (p_out_wr) else $error("output data not loaded");
	property p_fclr_rst;
		$rose(rstn) |-> fifo_clear;
	endproperty
	a_fclr_rst: assert property (p_fclr_rst) else $error("fifo not cleared by reset");
	property p_fclr_set;
		clr_wr |-> ##[1:3] fifo_clear;
	endproperty
	a_fclr_set: assert property (p_fclr_set) else $error("fifo reset bit ignored");
	c_irq: cover property ($rose(irq_request));
	c_rise: cover property (st_rd ##1 reg_rdata[4]);
	c_oe: cover property (io_oe != '0);
endmodule
bind parallel_io_change_detect pio_chk #(.LINES(LINES)) i_pio_chk (
	.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.io_out(io_out), .io_oe(io_oe), .parallel_enable(parallel_enable), .fifo_clear(fifo_clear),
	.channel_irq_lines(channel_irq_lines), .irq_request(irq_request)
);
`default_nettype wire

// file: tb/ttl_lines.sv
// External devices on the upper parallel lines.
`timescale 1ns/1ps
`default_nettype none
module ttl_lines (
	// Port side
	input  wire logic [31:0] io_out,
	input  wire logic [31:0] io_oe,
	// Far side
	input  wire logic [31:0] ext_drive,
	output logic      [31:0] io_in
);
	// A driven line reads its own level; the far devices own the rest.
	assign io_in = (io_oe & io_out) | (~io_oe & ext_drive);
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the upper parallel line block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; $display("Error %s exp %h got %h", nm, e, s); end end
module tb;
	logic        core_clk = 0, rstn = 0, reg_wr_en = 0, reg_rd_en = 0, pe = 0, osc = 0, synth = 0;
	logic [7:0]  reg_addr = 0, chan = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, io_in, io_out, io_oe, ext = 0, got;
	logic        reg_rvalid, fifo_clear, irq_request;
	logic [13:0] fifo_level = 0, thr;
	logic [31:0] m[0:17];
	int          fails = 0, n_compared = 0, n;
	always #2 core_clk = ~core_clk;
	// References are offset by 1 ns so that their edges never meet a clock edge.
	initial #1 forever #10 osc = ~osc;
	initial #1 forever #6 synth = ~synth;
	parallel_io_change_detect i_parallel_io_change_detect (.core_clk, .rstn, .reg_addr, .reg_wr_en,
		.reg_rd_en, .reg_wdata, .reg_rdata, .reg_rvalid, .io_in, .io_out, .io_oe, .parallel_enable(pe),
		.osc_ref(osc), .synth_output_a(synth), .fifo_level, .fifo_clear, .channel_irq_lines(chan),
		.irq_request);
	ttl_lines i_ttl_lines (.io_out, .io_oe, .ext_drive(ext), .io_in);
	function logic [31:0] pins();
		pins = (m[3] & {32{pe}} & m[4]) | (~(m[3] & {32{pe}}) & ext);
	endfunction
	function logic [31:0] expv(input logic [7:0] a);
		logic rs, fs, lr, lm, irq;
		rs = |(m[15] & m[6]);
		fs = |(m[16] & m[7]);
		lr = fifo_level >= m[12][13:0];
		lm = lr & m[10][11];
		irq = m[0][0] & (m[0][1] | |(m[15] & m[8]) | |(m[16] & m[9])) | lm | |chan;
		case (a)
			8'h08: expv = {irq, 7'h00, chan, lm, 9'h000, fs, rs, 3'h0, m[0][1]};
			8'h10: expv = pins();
			8'h14: expv = m[4];
			8'h2C: expv = {lm, lr, fifo_level, 16'h0000};
			default: expv = m[a[6:2]];
		endcase
	endfunction
	task cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		cyc(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1;
		cyc(1);
		reg_wr_en = 0;
		case (a)
			8'h00: m[0] = d & pio_pkg::BASE_WMASK;
			8'h28: m[10] = d & pio_pkg::CTRL_WMASK;
			8'h30: m[12] = {18'h0, d[13:0]};
			8'h3C, 8'h40: m[a[6:2]] &= ~d;
			8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24: m[a[6:2]] = d;
			default: ;
		endcase
	endtask
	task rc(input logic [7:0] a);
		cyc(1);
		reg_addr = a;
		reg_rd_en = 1;
		cyc(1);
		reg_rd_en = 0;
		got = expv(a);
		`CHK("rvalid", 1'b1, reg_rvalid)
		`CHK($sformatf("reg %h", a), got, reg_rdata)
		if (a == 8'h08) `CHK("irq", got[31], irq_request)
	endtask
	task step(input logic [31:0] e, input logic [31:0] l);
		logic [31:0] o;
		o = pins();
		wr(8'h10, l);
		ext = e;
		cyc(300);
		m[15] |= m[6] & ~o & pins();
		m[16] |= m[7] & o & ~pins();
	endtask
	task hi(output int c);
		c = 0;
		for (int i = 0; i < 200 && io_out[0] !== 1'b0; i++) cyc(1);
		for (int i = 0; i < 200 && io_out[0] !== 1'b1; i++) cyc(1);
		while (c < 200 && io_out[0] === 1'b1)
		begin
			c++;
			cyc(1);
		end
	endtask
	task end_sim;
		$display("compared %0d fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		fails++;
		end_sim;
	end
	initial
	begin
		void'($urandom(94557));
		for (int i = 0; i <= 17; i++) m[i] = 0;
		cyc(2);
		rstn = 1;
		for (int a = 0; a <= 'h44; a += 4) rc(a[7:0]);
		for (int a = 'h0C; a <= 'h30; a += 4) wr(a[7:0], $urandom);
		for (int a = 0; a <= 'h44; a += 4) rc(a[7:0]);
		$display("registers done");
		wr(8'h28, 0);
		pe = 1;
		wr(8'h10, $urandom);
		wr(8'h0C, $urandom);
		ext = $urandom;
		rc(8'h10);
		`CHK("oe", m[3], io_oe)
		pe = 0;
		rc(8'h10);
		$display("pins done");
		pe = 1;
		wr(8'h18, '1);
		wr(8'h1C, '1);
		wr(8'h20, 0);
		wr(8'h24, 0);
		wr(8'h28, 32'h0080);
		cyc(200);
		wr(8'h3C, '1);
		wr(8'h40, '1);
		repeat (3)
		begin
			step($urandom, $urandom);
			rc(8'h3C);
			rc(8'h40);
			rc(8'h08);
		end
		wr(8'h3C, $urandom);
		wr(8'h40, $urandom);
		rc(8'h3C);
		rc(8'h40);
		wr(8'h18, $urandom);
		wr(8'h1C, $urandom);
		rc(8'h08);
		wr(8'h20, $urandom);
		wr(8'h24, $urandom);
		rc(8'h08);
		wr(8'h00, 1);
		rc(8'h08);
		$display("edges done");
		wr(8'h3C, '1);
		wr(8'h40, '1);
		wr(8'h00, 2);
		rc(8'h08);
		wr(8'h00, 3);
		rc(8'h08);
		wr(8'h00, 0);
		chan = $urandom | 1;
		rc(8'h08);
		chan = 0;
		$display("interrupts done");
		thr = 14'($urandom) | 1;
		wr(8'h30, {18'h0, thr});
		fifo_level = thr;
		wr(8'h28, 32'h0880);
		rc(8'h08);
		rc(8'h2C);
		fifo_level = thr - 1;
		rc(8'h08);
		fifo_level = thr;
		wr(8'h28, 32'h0080);
		rc(8'h08);
		rc(8'h2C);
		wr(8'h28, 1);
		cyc(2);
		`CHK("fifo_clear", 1'b1, fifo_clear)
		wr(8'h28, 0);
		cyc(2);
		`CHK("fifo_clear", 1'b0, fifo_clear)
		$display("level done");
		wr(8'h0C, 1);
		wr(8'h28, 32'h0180);
		hi(n);
		`CHK("osc high", 1'b1, n >= 24 && n <= 26)
		wr(8'h28, 32'h4180);
		cyc(100);
		hi(n);
		`CHK("synth high", 1'b1, n >= 14 && n <= 16)
		$display("test clock done");
		rstn = 0;
		cyc(2);
		rstn = 1;
		for (int i = 0; i <= 17; i++) m[i] = 0;
		rc(8'h0C);
		$display("second reset done");
		end_sim;
	end
endmodule
`default_nettype wire
